/* File: common/jbd_pkg.sv */
// Package of opcode fields, constants and types for the jump and branch decoder
package jbd_pkg;
  localparam int WORD_W = 24;
  localparam int CCR_W = 8;
  localparam int SR_W = 24;
  localparam int SP_W = 6;
  // Opcode templates; fields are masked out before comparing
  localparam logic [23:0] OPC_BIT_EA = 24'h0a4080;
  localparam logic [23:0] MSK_BIT_EA = 24'hffc0a0;
  localparam logic [23:0] OPC_BIT_AA = 24'h0a0080;
  localparam logic [23:0] MSK_BIT_AA = 24'hffc0a0;
  localparam logic [23:0] OPC_BIT_PP = 24'h0a8080;
  localparam logic [23:0] MSK_BIT_PP = 24'hffc0a0;
  localparam logic [23:0] OPC_BIT_QQ = 24'h018080;
  localparam logic [23:0] MSK_BIT_QQ = 24'hffc0a0;
  localparam logic [23:0] OPC_BIT_REG = 24'h0ac000;
  localparam logic [23:0] MSK_BIT_REG = 24'hffc0e0;
  localparam logic [23:0] OPC_JMP_EA = 24'h0ac080;
  localparam logic [23:0] MSK_JMP_EA = 24'hffc0ff;
  localparam logic [23:0] OPC_JMP_SH = 24'h0c0000;
  localparam logic [23:0] MSK_JMP_SH = 24'hfff000;
  localparam logic [23:0] OPC_JSC_EA = 24'h0bc0a0;
  localparam logic [23:0] MSK_JSC_EA = 24'hffc0f0;
  localparam logic [23:0] OPC_JSC_SH = 24'h0f0000;
  localparam logic [23:0] MSK_JSC_SH = 24'hff0000;
  // Field positions
  localparam int BIT_LSB = 0;
  localparam int BIT_W = 5;
  localparam int SPACE_POS = 6;
  localparam int MEMF_POS = 7;
  localparam int EAF_LSB = 8;
  localparam int EAF_W = 6;
  localparam int SHORT_W = 12;
  localparam int CC_SH_LSB = 12;
  localparam int CC_EA_LSB = 0;
  localparam int CC_W = 4;
  localparam int CCR_S_POS = 7;
  localparam int CCR_L_POS = 6;
  localparam logic [4:0] MAX_BIT = 5'h17;
  localparam logic [23:0] PP_BASE = 24'hffffc0;
  localparam logic [23:0] QQ_BASE = 24'hffff80;
  // Condition-code bit positions inside the code byte
  localparam int CC_C = 0;
  localparam int CC_V = 1;
  localparam int CC_Z = 2;
  localparam int CC_N = 3;
  localparam int CC_U = 4;
  localparam int CC_E = 5;
  typedef enum logic [2:0] {
    JBD_SRC_NONE, JBD_SRC_EA, JBD_SRC_ABS, JBD_SRC_REG
  } jbd_src_t;
  typedef enum logic [2:0] {
    JBD_IDLE, JBD_EXT, JBD_OPND, JBD_PUSH
  } jbd_state_t;
endpackage

/* File: hw/jbd_cond.sv */
// Condition-code evaluator for the conditional subroutine jump
`timescale 1ns/10ps
`default_nettype none
module jbd_cond
  import jbd_pkg::*;
(
  input wire logic [CC_W-1:0] cond,
  input wire logic [CCR_W-1:0] condition_code_byte,
  output logic holds
);
  logic c, v, z, n, u, e, l, s;
  always_comb begin
    c = condition_code_byte[CC_C];
    v = condition_code_byte[CC_V];
    z = condition_code_byte[CC_Z];
    n = condition_code_byte[CC_N];
    u = condition_code_byte[CC_U];
    e = condition_code_byte[CC_E];
    l = condition_code_byte[CCR_L_POS];
    s = condition_code_byte[CCR_S_POS];
    // Standard sixteen-entry condition table
    unique case (cond)
      4'h0: holds = !c;
      4'h1: holds = !(n ^ v);
      4'h2: holds = !z;
      4'h3: holds = !n;
      4'h4: holds = !(z | ((!u) & (!e)));
      4'h5: holds = !e;
      4'h6: holds = !l;
      4'h7: holds = !(z | (n ^ v));
      4'h8: holds = c;
      4'h9: holds = n ^ v;
      4'ha: holds = z;
      4'hb: holds = n;
      4'hc: holds = z | ((!u) & (!e));
      4'hd: holds = e;
      4'he: holds = l;
      4'hf: holds = z | (n ^ v);
    endcase
    if (s && 1'b0) begin
      holds = 1'b0;
    end
  end
endmodule
`default_nettype wire

/* File: hw/jbd_decoder.sv */
// Jump, bit-test jump and conditional subroutine jump decode and execute
`timescale 1ns/10ps
`default_nettype none
//
// Contract
// - Bit clear loads PC from extension
// - Bit number from opcode bits 4..0
// - Bit set: advance PC, drop target
// - Address register updated either way
// - Indirect modes fetch X or Y operand
// - Absolute and peripheral short addresses
// - Bit 7 set, bit 6 space select
// - Register form tests chosen register bit
// - Bit-test jumps are two words
// - Update CONDITION_CODE_BYTE bits 7,6 only
// - Unconditional jump loads effective address
// - Short forms zero-extend 12-bit address
// - Jumps leave condition codes unchanged
// - Taken subroutine jump pushes PC, SR
// - Failed subroutine jump pushes nothing
// - Address update even when false
// - Condition field position per form
// - Fast short-jump mode accepted in ea
module jbd_decoder
  import jbd_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic instr_valid,
  input wire logic [WORD_W-1:0] instr_word,
  input wire logic [WORD_W-1:0] ext_word,
  input wire logic [WORD_W-1:0] pc_cur,
  input wire logic [CCR_W-1:0] ccr_cur,
  input wire logic [SR_W-1:0] sr_cur,
  input wire logic [SP_W-1:0] sp_cur,
  input wire logic [WORD_W-1:0] ea_addr,
  input wire logic opnd_valid,
  input wire logic [WORD_W-1:0] opnd_data,
  input wire logic ccr_s_new,
  input wire logic ccr_l_new,
  output logic busy,
  output logic done,
  output logic illegal,
  output logic ea_update,
  output logic [EAF_W-1:0] ea_mode,
  output logic mem_rd,
  output logic mem_space_y,
  output logic [WORD_W-1:0] mem_addr,
  output logic reg_rd,
  output logic [EAF_W-1:0] reg_sel,
  output logic pc_load,
  output logic [WORD_W-1:0] pc_next,
  output logic ccr_we,
  output logic [CCR_W-1:0] ccr_next,
  output logic stack_we,
  output logic [SP_W-1:0] stack_pointer,
  output logic [WORD_W-1:0] stack_high_word,
  output logic [SR_W-1:0] stack_low_word
);
  import jbd_pkg::*;

  typedef struct packed {
    jbd_state_t st;
    logic [WORD_W-1:0] ins;
    logic [WORD_W-1:0] tgt;
    logic is_sub;
    logic busy;
    logic done;
    logic illegal;
    logic ea_update;
    logic [EAF_W-1:0] ea_mode;
    logic mem_rd;
    logic mem_space_y;
    logic [WORD_W-1:0] mem_addr;
    logic reg_rd;
    logic [EAF_W-1:0] reg_sel;
    logic pc_load;
    logic [WORD_W-1:0] pc_next;
    logic ccr_we;
    logic [CCR_W-1:0] ccr_next;
    logic stack_we;
    logic [SP_W-1:0] stack_pointer;
    logic [WORD_W-1:0] stack_high_word;
    logic [SR_W-1:0] stack_low_word;
  } jbd_reg_t;

  jbd_reg_t s_q, s_d;

  // ----------------------------------------
  // Opcode classification
  // ----------------------------------------
  logic is_bit_ea, is_bit_aa, is_bit_pp, is_bit_qq, is_bit_reg, is_bit;
  logic is_jmp_ea, is_jmp_sh, is_jsc_ea, is_jsc_sh;
  logic [BIT_W-1:0] bitno;
  logic [CC_W-1:0] cond;
  logic cond_ok;
  logic [5:0] short6;
  logic opnd_bit;

  assign is_bit_ea = (instr_word & MSK_BIT_EA) == OPC_BIT_EA;
  assign is_bit_aa = (instr_word & MSK_BIT_AA) == OPC_BIT_AA;
  assign is_bit_pp = (instr_word & MSK_BIT_PP) == OPC_BIT_PP;
  assign is_bit_qq = (instr_word & MSK_BIT_QQ) == OPC_BIT_QQ;
  assign is_bit_reg = (instr_word & MSK_BIT_REG) == OPC_BIT_REG;
  assign is_bit = is_bit_ea | is_bit_aa | is_bit_pp | is_bit_qq | is_bit_reg;
  assign is_jmp_ea = (instr_word & MSK_JMP_EA) == OPC_JMP_EA;
  assign is_jmp_sh = (instr_word & MSK_JMP_SH) == OPC_JMP_SH;
  assign is_jsc_ea = (instr_word & MSK_JSC_EA) == OPC_JSC_EA;
  assign is_jsc_sh = (instr_word & MSK_JSC_SH) == OPC_JSC_SH;
  assign bitno = instr_word[BIT_LSB +: BIT_W];
  assign short6 = instr_word[EAF_LSB +: EAF_W];
  // Condition sits in a different place for each form
  assign cond = is_jsc_sh ? instr_word[CC_SH_LSB +: CC_W]
                          : instr_word[CC_EA_LSB +: CC_W];
  assign opnd_bit = opnd_data[s_q.ins[BIT_LSB +: BIT_W]];

  jbd_cond u_cond (
    .cond(cond),
    .condition_code_byte(ccr_cur),
    .holds(cond_ok)
  );

  // ----------------------------------------
  // Next-state logic
  // ----------------------------------------
  always_comb begin
    s_d = s_q;
    s_d.done = 1'b0;
    s_d.illegal = 1'b0;
    s_d.ea_update = 1'b0;
    s_d.mem_rd = 1'b0;
    s_d.reg_rd = 1'b0;
    s_d.pc_load = 1'b0;
    s_d.ccr_we = 1'b0;
    s_d.stack_we = 1'b0;
    unique case (s_q.st)
      JBD_IDLE: begin
        s_d.busy = 1'b0;
        if (instr_valid) begin
          s_d.ins = instr_word;
          s_d.pc_next = pc_cur + 24'h000001;
          if (is_bit && bitno > MAX_BIT) begin
            s_d.illegal = 1'b1;
            s_d.done = 1'b1;
          end else if (is_bit) begin
            // Second word is always the target, even if it goes unused
            s_d.tgt = ext_word;
            s_d.pc_next = pc_cur + 24'h000002;
            s_d.busy = 1'b1;
            s_d.st = JBD_OPND;
            s_d.ea_update = is_bit_ea;
            s_d.ea_mode = short6;
            s_d.mem_space_y = instr_word[SPACE_POS];
            s_d.mem_rd = is_bit_ea | is_bit_aa | is_bit_pp | is_bit_qq;
            s_d.reg_rd = is_bit_reg;
            s_d.reg_sel = short6;
            if (is_bit_ea) begin
              s_d.mem_addr = ea_addr;
            end else if (is_bit_aa) begin
              s_d.mem_addr = {18'h00000, short6};
            end else if (is_bit_pp) begin
              s_d.mem_addr = PP_BASE | {18'h00000, short6};
            end else begin
              s_d.mem_addr = QQ_BASE | {18'h00000, short6};
            end
          end else if (is_jmp_sh || is_jsc_sh) begin
            s_d.tgt = {12'h000, instr_word[SHORT_W-1:0]};
            s_d.is_sub = is_jsc_sh;
            s_d.busy = 1'b1;
            s_d.st = JBD_EXT;
            if (is_jsc_sh && !cond_ok) begin
              s_d.st = JBD_IDLE;
              s_d.busy = 1'b0;
              s_d.pc_load = 1'b1;
              s_d.done = 1'b1;
            end
          end else if (is_jmp_ea || is_jsc_ea) begin
            s_d.tgt = ea_addr;
            s_d.ea_update = 1'b1;
            s_d.ea_mode = short6;
            s_d.is_sub = is_jsc_ea;
            s_d.busy = 1'b1;
            s_d.st = JBD_EXT;
            if (is_jsc_ea && !cond_ok) begin
              // Extension ignored; PC still only steps by one here
              s_d.st = JBD_IDLE;
              s_d.busy = 1'b0;
              s_d.pc_load = 1'b1;
              s_d.done = 1'b1;
            end
          end
        end
      end
      JBD_EXT: begin
        // Condition codes untouched on both jump kinds
        s_d.ccr_we = 1'b0;
        if (s_q.is_sub) begin
          s_d.stack_pointer = sp_cur + 6'h01;
          s_d.stack_high_word = s_q.pc_next;
          s_d.stack_low_word = sr_cur;
          s_d.stack_we = 1'b1;
          s_d.st = JBD_PUSH;
        end else begin
          s_d.pc_next = s_q.tgt;
          s_d.pc_load = 1'b1;
          s_d.done = 1'b1;
          s_d.busy = 1'b0;
          s_d.st = JBD_IDLE;
        end
      end
      JBD_PUSH: begin
        s_d.pc_next = s_q.tgt;
        s_d.pc_load = 1'b1;
        s_d.done = 1'b1;
        s_d.busy = 1'b0;
        s_d.st = JBD_IDLE;
      end
      JBD_OPND: begin
        if (opnd_valid) begin
          if (!opnd_bit) begin
            s_d.pc_next = s_q.tgt;
          end
          // Else keep PC plus two and drop the target
          s_d.pc_load = 1'b1;
          s_d.ccr_we = 1'b1;
          s_d.ccr_next = ccr_cur;
          s_d.ccr_next[CCR_S_POS] = ccr_s_new;
          s_d.ccr_next[CCR_L_POS] = ccr_l_new;
          s_d.done = 1'b1;
          s_d.busy = 1'b0;
          s_d.st = JBD_IDLE;
        end
      end
      default: begin
        s_d.st = JBD_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign busy = s_q.busy;
  assign done = s_q.done;
  assign illegal = s_q.illegal;
  assign ea_update = s_q.ea_update;
  assign ea_mode = s_q.ea_mode;
  assign mem_rd = s_q.mem_rd;
  assign mem_space_y = s_q.mem_space_y;
  assign mem_addr = s_q.mem_addr;
  assign reg_rd = s_q.reg_rd;
  assign reg_sel = s_q.reg_sel;
  assign pc_load = s_q.pc_load;
  assign pc_next = s_q.pc_next;
  assign ccr_we = s_q.ccr_we;
  assign ccr_next = s_q.ccr_next;
  assign stack_we = s_q.stack_we;
  assign stack_pointer = s_q.stack_pointer;
  assign stack_high_word = s_q.stack_high_word;
  assign stack_low_word = s_q.stack_low_word;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  sequence s_push;
    stack_we ##1 pc_load;
  endsequence

  a_clr_taken: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (s_q.st == JBD_OPND && opnd_valid && !opnd_bit) |=> pc_load && pc_next == $past(s_q.tgt))
    else $error("bit clear did not load target");
  a_set_skip: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (s_q.st == JBD_OPND && opnd_valid && opnd_bit) |=> pc_next == $past(s_q.pc_next))
    else $error("bit set did not skip");
  a_bad_bitno: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (s_q.st == JBD_IDLE && instr_valid && is_bit && bitno > MAX_BIT) |=> illegal && !busy)
    else $error("bit number not flagged");
  a_ea_update: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (s_q.st == JBD_IDLE && instr_valid && is_jsc_ea) |=> ea_update)
    else $error("address update skipped");
  a_jsc_false: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (s_q.st == JBD_IDLE && instr_valid && (is_jsc_ea || is_jsc_sh) && !cond_ok)
      |=> !stack_we ##1 !stack_we)
    else $error("false condition pushed");
  a_jsc_push: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (s_q.st == JBD_IDLE && instr_valid && is_jsc_sh && cond_ok) |=> ##1 s_push)
    else $error("push sequence missing");
  a_ccr_keep: assert property (@(posedge ref_clk) disable iff (!rst_n)
    ccr_we |-> ccr_next[5:0] == $past(ccr_cur[5:0]))
    else $error("low condition bits changed");
  a_jump_nccr: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (s_q.st == JBD_EXT || s_q.st == JBD_PUSH) |=> !ccr_we)
    else $error("jump wrote condition codes");
  a_short_ext: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (s_q.st == JBD_IDLE && instr_valid && is_jmp_sh)
      |=> ##1 pc_next == {12'h000, $past(instr_word[11:0], 2)})
    else $error("short target not zero extended");
endmodule
`default_nettype wire

/* File: tb/jbd_core_model.sv */
// Behavioural memory and register-file side that answers operand reads
`timescale 1ns/10ps
`default_nettype none
module jbd_core_model (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic mem_rd,
  input wire logic reg_rd,
  input wire logic [23:0] op_val,
  input wire logic [3:0] op_dly,
  output logic opnd_valid,
  output logic [23:0] opnd_data
);
  // ----------------------------------------
  // Operand return after a programmable wait
  // ----------------------------------------
  logic pend = 1'b0;
  logic [3:0] cnt = 4'h0;
  logic [23:0] last = 24'h0;
  initial begin
    opnd_valid = 1'b0;
    opnd_data = 24'hffffff;
  end
  // Idle data shows the inverse of the last word, so a late sample is not rescued
  always @(negedge ref_clk) begin
    opnd_valid <= 1'b0;
    opnd_data <= ~last;
    if (!rst_n) begin
      pend = 1'b0;
    end else begin
      if (mem_rd || reg_rd) begin
        pend = 1'b1;
        cnt = op_dly;
      end
      if (pend && cnt == 4'h0) begin
        pend = 1'b0;
        opnd_valid <= 1'b1;
        opnd_data <= op_val;
        last = op_val;
      end else if (pend) begin
        cnt = cnt - 4'h1;
      end
    end
  end
endmodule
`default_nettype wire

/* File: tb/jump_branch_decode_test.sv */
// Self-checking bench for the jump and bit-test jump decoder
`timescale 1ns/10ps
`default_nettype none
module jump_branch_decode_test;
  import jbd_pkg::*;
  // ---------------------------------
  // Signals, instances and helpers
  // ---------------------------------
  localparam logic [23:0] FORM [6] = '{24'h0a59c0, 24'h0a5980, 24'h0a3fc0, 24'h0a8580,
                                       24'h01bf80, 24'h0ace00};
  localparam logic [23:0] ADDR [6] = '{24'h123456, 24'h123456, 24'h00003f, 24'hffffc5,
                                       24'hffffbf, 24'h0};
  localparam logic [4:0] BITS [6] = '{5'h00, 5'h17, 5'h07, 5'h10, 5'h01, 5'h17};
  logic ref_clk, rst_n, instr_valid, opnd_valid, ccr_s_new, ccr_l_new;
  logic [23:0] instr_word, ext_word, pc_cur, ea_addr, opnd_data, mem_addr, pc_next;
  logic [23:0] sr_cur, stack_high_word, stack_low_word, op_val;
  logic [7:0] ccr_cur, ccr_next;
  logic [5:0] sp_cur, ea_mode, reg_sel, stack_pointer;
  logic busy, done, illegal, ea_update, mem_rd, mem_space_y, reg_rd, pc_load, ccr_we, stack_we;
  logic s_mem, s_reg, s_eau, s_stk, s_ccr, s_pcl, s_ill;
  logic [3:0] op_dly;
  int failures = 0;
  int tests_run = 0;
  int lat;
  jbd_decoder dut (.ref_clk, .rst_n, .instr_valid, .instr_word, .ext_word, .pc_cur, .ccr_cur,
    .sr_cur, .sp_cur, .ea_addr, .opnd_valid, .opnd_data, .ccr_s_new, .ccr_l_new, .busy, .done,
    .illegal, .ea_update, .ea_mode, .mem_rd, .mem_space_y, .mem_addr, .reg_rd, .reg_sel,
    .pc_load, .pc_next, .ccr_we, .ccr_next, .stack_we, .stack_pointer, .stack_high_word,
    .stack_low_word);
  jbd_core_model model (.ref_clk, .rst_n, .mem_rd, .reg_rd, .op_val, .op_dly, .opnd_valid,
    .opnd_data);
  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %0t %s", $time, what);
    end
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // Issues one instruction and gathers every strobe until completion
  task automatic run(input logic [23:0] iw, input logic [23:0] ew);
    {s_mem, s_reg, s_eau, s_stk, s_ccr, s_pcl, s_ill} = '0;
    @(negedge ref_clk);
    instr_word = iw;
    ext_word = ew;
    instr_valid = 1'b1;
    for (lat = 1; lat < 30; lat++) begin
      @(negedge ref_clk);
      instr_valid = 1'b0;
      {s_mem, s_reg, s_eau, s_stk, s_ccr, s_pcl, s_ill} =
        {s_mem, s_reg, s_eau, s_stk, s_ccr, s_pcl, s_ill} |
        {mem_rd, reg_rd, ea_update, stack_we, ccr_we, pc_load, illegal};
      if (done === 1'b1) begin
        chk(busy, 1'b0, "idle at completion");
        break;
      end
      chk(busy, 1'b1, "busy while working");
    end
    if (lat == 30) begin
      failures++;
      $display("[FAIL] %0t no completion", $time);
      print_verdict();
    end
  endtask
  // ---------------------------------
  // Scenarios
  // ---------------------------------
  task automatic t_jump();
    pc_cur = 24'h000100;
    ea_addr = 24'h123456;
    ccr_cur = 8'h5a;
    run(24'h0c0abc, 24'h0);
    chk(32'(lat), 32'd2, "short jump latency");
    chk(pc_next, 24'h000abc, "short jump target");
    chk({s_pcl, s_ccr, s_stk}, 3'b100, "short jump strobes");
    run(24'h0ad980, 24'h0);
    chk(pc_next, 24'h123456, "ea jump target");
    chk({s_pcl, s_ccr, ea_mode}, {2'b10, 6'h19}, "ea jump strobes");
    $display("jump test finished");
  endtask
  task automatic t_subr();
    logic tk;
    sp_cur = 6'h0a;
    ea_addr = 24'h0abcde;
    for (int i = 0; i < 4; i++) begin
      ccr_cur = {7'h20, i[0]};
      sr_cur = {16'h00c3, ccr_cur};
      pc_cur = 24'h000200 + 24'(i);
      tk = (i[0] == i[1]);
      run({8'h0f, i[1], 3'h0, 12'h345}, 24'hffffff);
      chk(32'(lat), tk ? 32'd3 : 32'd1, "subroutine latency");
      chk(pc_next, tk ? 24'h000345 : pc_cur + 24'h1, "short target");
      chk({s_stk, s_ccr}, {tk, 1'b0}, "push strobe");
      if (tk) begin
        chk(stack_pointer, 6'h0b, "stack pointer");
        chk(stack_high_word, pc_cur + 24'h1, "return address");
        chk(stack_low_word, sr_cur, "saved status");
      end
      run({16'h0bd9, 4'ha, i[1], 3'h0}, 24'hffffff);
      chk(pc_next, tk ? ea_addr : pc_cur + 24'h1, "ea subroutine target");
      chk({s_eau, s_stk, ea_mode}, {1'b1, tk, 6'h19}, "ea update");
    end
    $display("subroutine test finished");
  endtask
  task automatic t_bit();
    logic clr;
    logic [4:0] b;
    pc_cur = 24'h000400;
    ea_addr = 24'h123456;
    ccr_cur = 8'h95;
    for (int k = 0; k < 6; k++) begin
      clr = ~k[0];
      b = BITS[k];
      op_val = clr ? ~(24'h1 << b) : (24'h1 << b);
      op_dly = 4'(k);
      ccr_s_new = k[0];
      ccr_l_new = k[1];
      run(FORM[k] | {19'h0, b}, 24'h765432);
      chk(pc_next, clr ? 24'h765432 : 24'h000402, "bit test target");
      chk(ccr_next, {ccr_s_new, ccr_l_new, 6'h15}, "bit test flags");
      chk({s_ccr, s_pcl, s_stk}, 3'b110, "bit test strobes");
      if (k == 5) begin
        chk({s_reg, s_mem, reg_sel}, {2'b10, 6'h0e}, "register operand");
      end else begin
        chk({s_mem, s_reg, mem_space_y, mem_addr}, {2'b10, FORM[k][6], ADDR[k]},
            "memory operand");
      end
      if (k < 2) begin
        chk({s_eau, ea_mode}, {1'b1, 6'h19}, "operand address update");
      end
    end
    $display("bit test finished");
  endtask
  task automatic t_illegal();
    run(24'h0ace18, 24'h765432);
    chk(32'(lat), 32'd1, "illegal latency");
    chk({s_ill, s_pcl, s_reg}, 3'b100, "illegal bit number");
    $display("illegal test finished");
  endtask
  initial begin
    {rst_n, instr_valid, ccr_s_new, ccr_l_new} = '0;
    {instr_word, ext_word, pc_cur, ea_addr, sr_cur, op_val} = '0;
    ccr_cur = 8'h0;
    sp_cur = 6'h0;
    op_dly = 4'h0;
    repeat (5) @(negedge ref_clk);
    rst_n = 1'b1;
    t_jump();
    t_subr();
    t_bit();
    t_illegal();
    print_verdict();
  end
endmodule
`default_nettype wire
